/* File: dma_trig_pkg.sv */
// constants for the dma trigger select and priority block
package dma_trig_pkg;
  localparam int         NCH           = 3;
  // register byte offsets
  localparam logic [7:0] ADDR_GCTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [3:0] CH_CTRL_OFS   = 4'h0;
  localparam logic [3:0] CH_SIZE_OFS   = 4'h4;
  // global_ctrl_1 fields
  localparam int         GC_NMI_BIT    = 0;
  localparam int         GC_ROT_BIT    = 1;
  // channel control fields
  localparam int         CC_TSEL_LSB   = 0;
  localparam int         CC_EN_BIT     = 4;
  localparam int         CC_MODE_LSB   = 5;
  localparam int         CC_DONE_BIT   = 7;
  // trigger codes
  localparam logic [3:0] TSEL_CONV     = 4'h6;
  localparam logic [3:0] TSEL_TA0      = 4'h7;
  localparam logic [3:0] TSEL_TB0      = 4'h8;
  localparam logic [3:0] TSEL_P1RX     = 4'h9;
  localparam logic [3:0] TSEL_P1TX     = 4'hA;
  localparam logic [3:0] TSEL_MULT     = 4'hB;
  localparam logic [3:0] TSEL_B0RX     = 4'hC;
  localparam logic [3:0] TSEL_B0TX     = 4'hD;
  localparam logic [3:0] TSEL_CHAIN    = 4'hE;
  localparam logic [3:0] TSEL_EXT      = 4'hF;
  // transfer modes
  localparam logic [1:0] MODE_SINGLE   = 2'h0;
  localparam logic [1:0] MODE_BLOCK    = 2'h1;
  localparam logic [1:0] MODE_BURST    = 2'h2;
  // reset values
  localparam logic [3:0] TSEL_RST      = 4'h0;
  localparam logic [1:0] MODE_RST      = 2'h0;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [1:0] RR_RST        = 2'h0;
endpackage

/* File: dma_trig_arb.sv */
// dma trigger selection, abort control and channel priority arbiter
//
// Summary of operation
// R1 - code 0110 starts on conversion completion
// R2 - software-set conversion flag never triggers
// R3 - dma result access clears conversion flag
// R4 - sigma-delta completion triggers, same clear behaviour
// R5 - sigma-delta irq enable masks its trigger
// R6 - 0111 timer a cc0, clear, irq mask
// R7 - 1000 timer b cc0, clear, irq mask
// R8 - 1001 port 1 receive, clear, mask
// R9 - 1010 port 1 transmit, clear, mask
// R10 - 1011 multiplier ready for operand triggers
// R11 - 1100 port b0 receive, clear, mask
// R12 - 1101 port b0 transmit, clear, mask
// R13 - 1110 chains done flags, no clear
// R14 - 1111 external trigger pin requests transfer
// R15 - nmi aborts transfer when enabled
// R16 - clearing enable stops burst-block transfer
// R17 - default priority channel 0, 1, 2
// R18 - transfer in progress never preempted
// R19 - rotating: finished channel becomes lowest
// R20 - rotate bit cleared restores fixed order
// R21 - done flag sets when count hits zero
`timescale 1ns/10ps
`default_nettype none
module dma_trig_arb (
  input  wire logic        clk,                   // 50 MHz system clock
  input  wire logic        srst,                  // sync reset, high
  // ahb-lite slave
  input  wire logic        hsel,                  // slave select
  input  wire logic [31:0] haddr,                 // byte address
  input  wire logic [1:0]  htrans,                // transfer type
  input  wire logic        hwrite,                // write when high
  input  wire logic [2:0]  hsize,                 // word only
  input  wire logic [31:0] hwdata,                // write data
  input  wire logic        hready,                // bus ready
  output logic             hreadyout,             // always ready
  output logic             hresp,                 // always okay
  output logic [31:0]      hrdata,                // read data
  // trigger sources
  input  wire logic        conv_done_hw_set,      // hw conversion end pulse
  input  wire logic        conv_done_flag,        // flag level, status only
  input  wire logic        conv_result_access,    // dma read of result reg
  input  wire logic        sigma_delta_hw_set,    // master chan end pulse
  input  wire logic        sigma_delta_irq_enable,// masks sd trigger
  input  wire logic        sigma_delta_result_access, // dma read of sd reg
  input  wire logic        timer_a_cc0_flag,      // timer a cc0 flag
  input  wire logic        timer_a_cc0_irq_enable,// mask
  input  wire logic        timer_b_cc0_flag,      // timer b cc0 flag
  input  wire logic        timer_b_cc0_irq_enable,// mask
  input  wire logic        port1_rx_flag,         // port 1 receive
  input  wire logic        port1_rx_irq_enable,   // mask
  input  wire logic        port_a1_rx_flag,       // port a1 receive
  input  wire logic        port_a1_rx_irq_enable, // mask
  input  wire logic        port1_tx_flag,         // port 1 transmit
  input  wire logic        port1_tx_irq_enable,   // mask
  input  wire logic        port_a1_tx_flag,       // port a1 transmit
  input  wire logic        port_a1_tx_irq_enable, // mask
  input  wire logic        mult_ready,            // multiplier takes operand
  input  wire logic        port_b0_rx_flag,       // port b0 receive
  input  wire logic        port_b0_rx_irq_enable, // mask
  input  wire logic        port_b0_tx_flag,       // port b0 transmit
  input  wire logic        port_b0_tx_irq_enable, // mask
  input  wire logic        ext_trigger_in,        // external trigger pin
  input  wire logic        nmi,                   // non-maskable interrupt
  // flag clears
  output logic             conv_flag_clear,       // clear conversion flag
  output logic             sigma_delta_flag_clear,// clear sd flag
  output logic             timer_a_cc0_clear,     // clear at start
  output logic             timer_b_cc0_clear,     // clear at start
  output logic             port1_rx_clear,        // clear at start
  output logic             port1_tx_clear,        // clear at start
  output logic             port_b0_rx_clear,      // clear at start
  output logic             port_b0_tx_clear,      // clear at start
  // transfer engine
  output logic             xfer_start,            // grant pulse
  output logic             xfer_busy,             // transfer in progress
  output logic [1:0]       xfer_chan,             // granted channel
  output logic             xfer_abort,            // abort pulse
  input  wire logic        xfer_unit_done         // one unit moved
);
  typedef enum logic {ST_IDLE, ST_BUSY} arb_e;

  // ==========================================================================
  // state
  arb_e        st_q, st_d;
  logic [1:0]  act_q, act_d, rr_q, rr_d;
  logic        nmi_en_q, nmi_en_d, rot_q, rot_d;
  logic [3:0]  tsel_q [dma_trig_pkg::NCH];
  logic [3:0]  tsel_d [dma_trig_pkg::NCH];
  logic [1:0]  mode_q [dma_trig_pkg::NCH];
  logic [1:0]  mode_d [dma_trig_pkg::NCH];
  logic [15:0] cnt_q  [dma_trig_pkg::NCH];
  logic [15:0] cnt_d  [dma_trig_pkg::NCH];
  logic [2:0]  en_q, en_d, done_q, done_d, pend_q, pend_d;
  logic [2:0]  done_prev_q, trig;
  logic [15:0] lvl, lvl_q, rise;
  logic        conv_evt;
  logic        ph_wr_q, ph_wr_d;
  logic [7:0]  ph_addr_q, ph_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  clr_d, clr_q;
  logic        start_d, abort_d;
  logic [1:0]  first, pick;
  logic        found, finish;
  logic        acc;

  function automatic logic [1:0] nxt(input logic [1:0] c);
    nxt = (c == 2'h2) ? 2'h0 : c + 2'h1;
  endfunction

  // ==========================================================================
  // trigger sources
  always_comb begin
    lvl = 16'h0000;
    lvl[dma_trig_pkg::TSEL_TA0]  = timer_a_cc0_flag & ~timer_a_cc0_irq_enable;
    lvl[dma_trig_pkg::TSEL_TB0]  = timer_b_cc0_flag & ~timer_b_cc0_irq_enable;
    lvl[dma_trig_pkg::TSEL_P1RX] = (port1_rx_flag & ~port1_rx_irq_enable) |
                                 (port_a1_rx_flag & ~port_a1_rx_irq_enable);
    lvl[dma_trig_pkg::TSEL_P1TX] = (port1_tx_flag & ~port1_tx_irq_enable) |
                                 (port_a1_tx_flag & ~port_a1_tx_irq_enable);
    lvl[dma_trig_pkg::TSEL_MULT] = mult_ready;                       // R10
    lvl[dma_trig_pkg::TSEL_B0RX] = port_b0_rx_flag & ~port_b0_rx_irq_enable;
    lvl[dma_trig_pkg::TSEL_B0TX] = port_b0_tx_flag & ~port_b0_tx_irq_enable;
    lvl[dma_trig_pkg::TSEL_EXT]  = ext_trigger_in;                   // R14
  end
  // masked flags ride on the level so unmasking a set flag still fires
  assign rise = lvl & ~lvl_q; // R6 R7 R8 R9 R11 R12
  // only hardware completion pulses count; flag level is never watched
  assign conv_evt = conv_done_hw_set |
                    (sigma_delta_hw_set & ~sigma_delta_irq_enable); // R1 R2 R4 R5

  for (genvar g = 0; g < dma_trig_pkg::NCH; g++) begin : g_trig
    localparam int PRV = (g + dma_trig_pkg::NCH - 1) % dma_trig_pkg::NCH;
    always_comb begin
      case (tsel_q[g])
        dma_trig_pkg::TSEL_CONV:  trig[g] = conv_evt;
        dma_trig_pkg::TSEL_CHAIN: trig[g] = done_q[PRV] & ~done_prev_q[PRV]; // R13
        dma_trig_pkg::TSEL_TA0, dma_trig_pkg::TSEL_TB0,
        dma_trig_pkg::TSEL_P1RX, dma_trig_pkg::TSEL_P1TX,
        dma_trig_pkg::TSEL_MULT, dma_trig_pkg::TSEL_B0RX,
        dma_trig_pkg::TSEL_B0TX, dma_trig_pkg::TSEL_EXT:
          trig[g] = rise[tsel_q[g]];
        default: trig[g] = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // arbiter, channels and register file
  always_comb begin
    st_d = st_q;
    act_d = act_q;
    rr_d = rr_q;
    nmi_en_d = nmi_en_q;
    rot_d = rot_q;
    tsel_d = tsel_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    en_d = en_q;
    done_d = done_q;
    pend_d = pend_q;
    clr_d = 8'h00;
    start_d = 1'b0;
    abort_d = 1'b0;
    finish = 1'b0;
    found = 1'b0;
    pick = 2'h0;
    ph_wr_d = 1'b0;
    ph_addr_d = ph_addr_q;
    rdata_d = rdata_q;
    // priority search from the current highest channel
    first = rot_q ? rr_q : 2'h0; // R17 R20
    for (int k = 0; k < dma_trig_pkg::NCH; k++) begin
      if (!found && pend_q[first] && en_q[first] && cnt_q[first] != 16'h0000)
      begin
        found = 1'b1;
        pick = first;
      end
      first = nxt(first);
    end
    // software register writes in the data phase
    if (ph_wr_q) begin
      if (ph_addr_q == dma_trig_pkg::ADDR_GCTRL) begin
        nmi_en_d = hwdata[dma_trig_pkg::GC_NMI_BIT];
        rot_d = hwdata[dma_trig_pkg::GC_ROT_BIT];
      end else if (ph_addr_q[5:4] != 2'h0 && ph_addr_q[7:6] == 2'h0) begin
        if (ph_addr_q[3:0] == dma_trig_pkg::CH_CTRL_OFS) begin
          tsel_d[ph_addr_q[5:4] - 2'h1] =
            hwdata[dma_trig_pkg::CC_TSEL_LSB +: 4];
          mode_d[ph_addr_q[5:4] - 2'h1] =
            hwdata[dma_trig_pkg::CC_MODE_LSB +: 2];
          en_d[ph_addr_q[5:4] - 2'h1] = hwdata[dma_trig_pkg::CC_EN_BIT];
          if (hwdata[dma_trig_pkg::CC_DONE_BIT])
            done_d[ph_addr_q[5:4] - 2'h1] = 1'b0;
        end else if (ph_addr_q[3:0] == dma_trig_pkg::CH_SIZE_OFS) begin
          cnt_d[ph_addr_q[5:4] - 2'h1] = hwdata[15:0];
        end
      end
    end
    unique case (st_q)
      ST_IDLE: begin
        if (found) begin
          st_d = ST_BUSY;
          act_d = pick;
          start_d = 1'b1;
          pend_d[pick] = 1'b0;
          // source flags cleared at start; chained done flags are not
          clr_d[2] = tsel_q[pick] == dma_trig_pkg::TSEL_TA0;  // R6
          clr_d[3] = tsel_q[pick] == dma_trig_pkg::TSEL_TB0;  // R7
          clr_d[4] = tsel_q[pick] == dma_trig_pkg::TSEL_P1RX; // R8
          clr_d[5] = tsel_q[pick] == dma_trig_pkg::TSEL_P1TX; // R9
          clr_d[6] = tsel_q[pick] == dma_trig_pkg::TSEL_B0RX; // R11
          clr_d[7] = tsel_q[pick] == dma_trig_pkg::TSEL_B0TX; // R12
        end
      end
      ST_BUSY: begin
        // no other channel is looked at here: no preemption
        if (nmi && nmi_en_q) begin // R15
          abort_d = 1'b1;
          finish = 1'b1;
        end else if (!en_d[act_q] &&
                     mode_q[act_q][1] == dma_trig_pkg::MODE_BURST[1]) begin
          abort_d = 1'b1; // R16
          finish = 1'b1;
        end else if (xfer_unit_done) begin
          cnt_d[act_q] = cnt_q[act_q] - 16'h0001;
          if (cnt_q[act_q] == 16'h0001) begin
            done_d[act_q] = 1'b1; // R21
            en_d[act_q] = 1'b0;
            finish = 1'b1;
          end else if (mode_q[act_q] == dma_trig_pkg::MODE_SINGLE) begin
            finish = 1'b1;
          end
        end
        if (finish) begin
          st_d = ST_IDLE; // R18
          rr_d = nxt(act_q); // R19
        end
      end
    endcase
    // a new trigger outranks the clear at its own start
    pend_d = pend_d | trig;
    // dma access to a result register clears the converter flag
    clr_d[0] = conv_result_access; // R3
    clr_d[1] = sigma_delta_result_access; // R4
    // ahb address phase; reads sample state now, data out next cycle
    acc = hsel && hready && htrans[1];
    if (acc) begin
      ph_wr_d = hwrite;
      ph_addr_d = haddr[7:0];
      rdata_d = 32'h0000_0000;
      if (haddr[7:0] == dma_trig_pkg::ADDR_GCTRL) begin
        rdata_d[dma_trig_pkg::GC_NMI_BIT] = nmi_en_q;
        rdata_d[dma_trig_pkg::GC_ROT_BIT] = rot_q;
      end else if (haddr[7:0] == dma_trig_pkg::ADDR_STATUS) begin
        rdata_d[0] = st_q == ST_BUSY;
        rdata_d[2:1] = act_q;
        rdata_d[4:3] = rot_q ? rr_q : 2'h0;
        rdata_d[7:5] = pend_q;
        rdata_d[10:8] = done_q;
        rdata_d[11] = conv_done_flag;
      end else if (haddr[5:4] != 2'h0 && haddr[7:6] == 2'h0) begin
        if (haddr[3:0] == dma_trig_pkg::CH_CTRL_OFS) begin
          rdata_d[dma_trig_pkg::CC_TSEL_LSB +: 4] = tsel_q[haddr[5:4] - 2'h1];
          rdata_d[dma_trig_pkg::CC_EN_BIT] = en_q[haddr[5:4] - 2'h1];
          rdata_d[dma_trig_pkg::CC_MODE_LSB +: 2] = mode_q[haddr[5:4] - 2'h1];
          rdata_d[dma_trig_pkg::CC_DONE_BIT] = done_q[haddr[5:4] - 2'h1];
        end else if (haddr[3:0] == dma_trig_pkg::CH_SIZE_OFS) begin
          rdata_d[15:0] = cnt_q[haddr[5:4] - 2'h1];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      act_q <= 2'h0;
      rr_q <= dma_trig_pkg::RR_RST;
      nmi_en_q <= 1'b0;
      rot_q <= 1'b0;
      for (int i = 0; i < dma_trig_pkg::NCH; i++) begin
        tsel_q[i] <= dma_trig_pkg::TSEL_RST;
        mode_q[i] <= dma_trig_pkg::MODE_RST;
        cnt_q[i] <= dma_trig_pkg::CNT_RST;
      end
      en_q <= 3'h0;
      done_q <= 3'h0;
      done_prev_q <= 3'h0;
      pend_q <= 3'h0;
      lvl_q <= 16'h0000;
      clr_q <= 8'h00;
      xfer_start <= 1'b0;
      xfer_abort <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      act_q <= act_d;
      rr_q <= rr_d;
      nmi_en_q <= nmi_en_d;
      rot_q <= rot_d;
      tsel_q <= tsel_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      en_q <= en_d;
      done_q <= done_d;
      done_prev_q <= done_q;
      pend_q <= pend_d;
      lvl_q <= lvl;
      clr_q <= clr_d;
      xfer_start <= start_d;
      xfer_abort <= abort_d;
      ph_wr_q <= ph_wr_d;
      ph_addr_q <= ph_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign xfer_busy = st_q == ST_BUSY;
  assign xfer_chan = act_q;
  assign conv_flag_clear = clr_q[0];
  assign sigma_delta_flag_clear = clr_q[1];
  assign timer_a_cc0_clear = clr_q[2];
  assign timer_b_cc0_clear = clr_q[3];
  assign port1_rx_clear = clr_q[4];
  assign port1_tx_clear = clr_q[5];
  assign port_b0_rx_clear = clr_q[6];
  assign port_b0_tx_clear = clr_q[7];

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  fixed_prio_a: assert property (st_q == ST_IDLE && !rot_q && pend_q[0] &&
    en_q[0] && cnt_q[0] != 16'h0000 |=> xfer_start && xfer_chan == 2'h0) // R17
    else $error("channel 0 not granted first");
  no_preempt_a: assert property (xfer_busy && !finish |=>
    xfer_busy && $stable(xfer_chan)) // R18
    else $error("busy transfer changed channel");
  rr_rotate_a: assert property (xfer_busy && finish && rot_q |=>
    rr_q == nxt($past(act_q))) // R19
    else $error("rotation did not demote finished channel");
  rr_off_a: assert property (!rot_q && st_q == ST_IDLE && pend_q[1] &&
    en_q[1] && cnt_q[1] != 16'h0000 && !(pend_q[0] && en_q[0] &&
    cnt_q[0] != 16'h0000) |=> xfer_chan == 2'h1) // R20
    else $error("fixed order not used");
  nmi_abort_a: assert property (xfer_busy && nmi && nmi_en_q |=>
    !xfer_busy && xfer_abort) // R15
    else $error("nmi did not stop transfer");
  burst_stop_a: assert property (xfer_busy && !en_d[act_q] &&
    mode_q[act_q][1] && !(nmi && nmi_en_q) &&
    !(xfer_unit_done && cnt_q[act_q] == 16'h0001) |=>
    !xfer_busy && xfer_abort) // R16
    else $error("burst not stopped by enable clear");
  done_set_a: assert property (xfer_busy && xfer_unit_done &&
    cnt_q[act_q] == 16'h0001 && !abort_d |=>
    done_q[$past(act_q)] && !xfer_busy) // R21
    else $error("done flag not set at zero");
  ta_clear_a: assert property (st_q == ST_IDLE && found &&
    tsel_q[pick] == dma_trig_pkg::TSEL_TA0 |=> timer_a_cc0_clear
    && xfer_start) // R6
    else $error("timer a flag not cleared at start");
  chain_keep_a: assert property (xfer_start &&
    tsel_q[xfer_chan] == dma_trig_pkg::TSEL_CHAIN |-> !timer_a_cc0_clear &&
    !port1_rx_clear && !port_b0_rx_clear) // R13
    else $error("chained start cleared a source flag");

  rr_cover_c: cover property (rot_q && xfer_start ##[1:50] xfer_start);
  nmi_cover_c: cover property (xfer_busy && nmi && nmi_en_q);
  chain_cover_c: cover property (done_q[0] ##[1:20] xfer_start &&
    xfer_chan == 2'h1);
endmodule // dma_trig_arb
`default_nettype wire

/* File: dma_trig_peer.sv */
// partner model: transfer engine and peripheral event flags
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// engine answers each unit after DLY cycles; flags hold until cleared, except the multiplier flag, which also drops on unit_done
module dma_trig_peer #(
  parameter int DLY = 3
) (
  input  wire logic       clk,       // system clock
  input  wire logic       srst,      // sync reset
  input  wire logic       busy,      // transfer in progress
  output logic            unit_done, // one unit moved
  input  wire logic [6:0] src_set,   // event pulses from bench
  input  wire logic [6:0] src_clr,   // clears from the block
  output logic [6:0]      flags      // flag levels
);
  int cnt_q;
  always @(posedge clk) begin
    if (srst) begin
      cnt_q <= 0;
      unit_done <= 1'b0;
      flags <= '0;
    end else begin
      unit_done <= 1'b0;
      if (busy && !unit_done && cnt_q == DLY - 1) begin
        unit_done <= 1'b1;
        cnt_q <= 0;
      end else if (busy && !unit_done)
        cnt_q <= cnt_q + 1;
      else
        cnt_q <= 0;
      // multiplier drops ready once an operand is taken
      flags <= (flags | src_set) & ~src_clr & ~{2'b00, unit_done, 4'h0};
    end
  end
endmodule // dma_trig_peer
`default_nettype wire

/* File: dma_trigger_select_and_priority_bench.sv */
// self-checking bench for the dma trigger select and priority block
`timescale 1ns/10ps
`default_nettype none
module dma_trigger_select_and_priority_bench;
  // ==========================================================
  // signals
  logic        clk, srst, hsel, hwrite, unit_done, conv_set, conv_flag;
  logic        hreadyout, hresp, xfer_start, xfer_busy, xfer_abort;
  logic        conv_acc, sd_set, sd_ie, sd_acc, conv_clr, sd_clr, ext, nmi;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, xfer_chan;
  logic [6:0]  src_set, mask, flags;
  wire  [6:0]  clrs;
  logic [8:0]  q[$];
  int          n_fail = 0, num_checks = 0, n_abort = 0, n_cclr = 0, n_pre = 0;
  logic        busy_prev = 1'b0;
  assign clrs[4] = 1'b0;
  dma_trig_arb DUT (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .conv_done_hw_set(conv_set), .conv_done_flag(conv_flag),
    .conv_result_access(conv_acc), .sigma_delta_hw_set(sd_set),
    .sigma_delta_irq_enable(sd_ie), .sigma_delta_result_access(sd_acc),
    .timer_a_cc0_flag(flags[0]), .timer_a_cc0_irq_enable(mask[0]),
    .timer_b_cc0_flag(flags[1]), .timer_b_cc0_irq_enable(mask[1]),
    .port1_rx_flag(flags[2]), .port1_rx_irq_enable(mask[2]),
    .port_a1_rx_flag(1'b0), .port_a1_rx_irq_enable(mask[2]),
    .port1_tx_flag(flags[3]), .port1_tx_irq_enable(mask[3]),
    .port_a1_tx_flag(1'b0), .port_a1_tx_irq_enable(mask[3]),
    .mult_ready(flags[4]), .port_b0_rx_flag(flags[5]),
    .port_b0_rx_irq_enable(mask[5]), .port_b0_tx_flag(flags[6]),
    .port_b0_tx_irq_enable(mask[6]), .ext_trigger_in(ext), .nmi(nmi),
    .conv_flag_clear(conv_clr), .sigma_delta_flag_clear(sd_clr),
    .timer_a_cc0_clear(clrs[0]), .timer_b_cc0_clear(clrs[1]),
    .port1_rx_clear(clrs[2]), .port1_tx_clear(clrs[3]),
    .port_b0_rx_clear(clrs[5]), .port_b0_tx_clear(clrs[6]),
    .xfer_start(xfer_start), .xfer_busy(xfer_busy), .xfer_chan(xfer_chan),
    .xfer_abort(xfer_abort), .xfer_unit_done(unit_done)
  );
  dma_trig_peer #(.DLY(3)) peer (
    .clk(clk), .srst(srst), .busy(xfer_busy), .unit_done(unit_done),
    .src_set(src_set), .src_clr(clrs), .flags(flags)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // monitor: grants with their clears, aborts, flag clears
  always @(posedge clk) begin
    if (xfer_start === 1'b1) q.push_back({clrs, xfer_chan});
    if (xfer_start === 1'b1 && busy_prev === 1'b1) n_pre++;
    if (xfer_abort === 1'b1) n_abort++;
    if (conv_clr === 1'b1 || sd_clr === 1'b1) n_cclr++;
    busy_prev <= xfer_busy;
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
      k++;
      if (k > 50) begin
        n_fail++;
        close_out();
      end
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [31:0] a, m, exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(r & m, exp);
  endtask
  task automatic setup(input int ch, input logic [3:0] ts,
                       input logic [1:0] md, input logic [15:0] cnt);
    logic [31:0] base;
    base = 32'(16 * (ch + 1));
    wr(base + 32'h4, {16'h0000, cnt});
    // done flag written 1 to clear it, enable set
    wr(base, {24'h000000, 1'b1, md, 1'b1, ts});
  endtask
  // grants seen and engine idle again, bounded
  task automatic wait_q(input int n);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    while (q.size() < n || xfer_busy !== 1'b0) begin
      @(posedge clk);
      #1;
      k++;
      if (k > 400) begin
        n_fail++;
        close_out();
      end
    end
    @(posedge clk);
  endtask
  task automatic pulse_ext();
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_codes();
    int k;
    for (k = 0; k < 7; k++) begin
      q.delete();
      setup(0, dma_trig_pkg::TSEL_TA0 + 4'(k), dma_trig_pkg::MODE_SINGLE,
            16'h0001);
      mask <= 7'(1 << k);
      src_set <= 7'(1 << k);
      @(posedge clk);
      src_set <= '0;
      repeat (8) @(posedge clk);
      if (k != 4) check(32'(q.size()), 32'h0);
      mask <= '0;
      wait_q(1);
      check(32'(q[0]), 32'({(k == 4) ? 7'h00 : 7'(1 << k), 2'h0}));
      check(32'(flags), 32'h0);
    end
    $display("codes test over");
  endtask
  task automatic t_conv();
    q.delete();
    setup(1, dma_trig_pkg::TSEL_CONV, dma_trig_pkg::MODE_SINGLE, 16'h0001);
    conv_flag <= 1'b1;
    sd_ie <= 1'b1;
    sd_set <= 1'b1;
    @(posedge clk);
    sd_set <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(q.size()), 32'h0);
    sd_ie <= 1'b0;
    conv_set <= 1'b1;
    @(posedge clk);
    conv_set <= 1'b0;
    wait_q(1);
    check(32'(q[0][1:0]), 32'h1);
    conv_acc <= 1'b1;
    @(posedge clk);
    conv_acc <= 1'b0;
    sd_acc <= 1'b1;
    @(posedge clk);
    sd_acc <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(n_cclr), 32'h2);
    setup(1, dma_trig_pkg::TSEL_CONV, dma_trig_pkg::MODE_SINGLE, 16'h0001);
    sd_set <= 1'b1;
    @(posedge clk);
    sd_set <= 1'b0;
    wait_q(2);
    check(32'(q[1][1:0]), 32'h1);
    $display("converter test over");
  endtask
  task automatic t_prio();
    q.delete();
    setup(0, dma_trig_pkg::TSEL_MULT, dma_trig_pkg::MODE_SINGLE, 16'h0001);
    setup(1, dma_trig_pkg::TSEL_EXT, dma_trig_pkg::MODE_BLOCK, 16'h0002);
    setup(2, dma_trig_pkg::TSEL_EXT, dma_trig_pkg::MODE_SINGLE, 16'h0001);
    pulse_ext();
    repeat (3) @(posedge clk);
    // higher channel arrives while channel 1 moves its block
    src_set <= 7'h10;
    @(posedge clk);
    src_set <= '0;
    wait_q(3);
    check(32'({q[0][1:0], q[1][1:0], q[2][1:0]}), 32'h12);
    $display("priority test over");
  endtask
  task automatic rr(input logic rot, input logic [1:0] first);
    wr(32'(dma_trig_pkg::ADDR_GCTRL), {30'h0, rot, 1'b0});
    q.delete();
    setup(1, dma_trig_pkg::TSEL_MULT, dma_trig_pkg::MODE_SINGLE, 16'h0001);
    setup(0, dma_trig_pkg::TSEL_EXT, dma_trig_pkg::MODE_SINGLE, 16'h0001);
    setup(2, dma_trig_pkg::TSEL_EXT, dma_trig_pkg::MODE_SINGLE, 16'h0001);
    src_set <= 7'h10;
    @(posedge clk);
    src_set <= '0;
    wait_q(1);
    pulse_ext();
    wait_q(3);
    check(32'({q[1][1:0], q[2][1:0]}), 32'({first, first ^ 2'h2}));
    $display("rotation test over");
  endtask
  task automatic t_abort();
    wr(32'(dma_trig_pkg::ADDR_GCTRL), 32'h1);
    q.delete();
    setup(0, dma_trig_pkg::TSEL_EXT, dma_trig_pkg::MODE_BLOCK, 16'h0008);
    pulse_ext();
    repeat (4) @(posedge clk);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    wait_q(1);
    check(32'(n_abort), 32'h1);
    wr(32'h10, 32'h0);
    setup(2, dma_trig_pkg::TSEL_EXT, dma_trig_pkg::MODE_BURST, 16'h0008);
    pulse_ext();
    repeat (4) @(posedge clk);
    wr(32'h30, {24'h0, 1'b0, dma_trig_pkg::MODE_BURST, 1'b0, 4'hF});
    wait_q(2);
    check(32'({n_abort[3:0], 2'(q[1][1:0])}), 32'h0A);
    $display("abort test over");
  endtask
  task automatic t_chain();
    q.delete();
    setup(1, dma_trig_pkg::TSEL_CHAIN, dma_trig_pkg::MODE_SINGLE, 16'h0001);
    setup(0, dma_trig_pkg::TSEL_EXT, dma_trig_pkg::MODE_SINGLE, 16'h0001);
    pulse_ext();
    wait_q(2);
    check(32'(q[1][1:0]), 32'h1);
    rd_chk(32'(dma_trig_pkg::ADDR_STATUS), 32'hF00, 32'hB00);
    $display("chain test over");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hwdata = 32'h0;
    {conv_set, conv_flag, conv_acc, sd_set, sd_ie, sd_acc, ext, nmi} = '0;
    src_set = '0;
    mask = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    // unmapped write must leave the controls alone
    wr(32'h80, 32'hFFFFFFFF);
    rd_chk(32'(dma_trig_pkg::ADDR_GCTRL), 32'hFF, 32'h0);
    t_codes();
    t_conv();
    t_prio();
    rr(1'b1, 2'h2);
    rr(1'b0, 2'h0);
    t_abort();
    t_chain();
    check(32'(n_pre), 32'h0);
    close_out();
  end
endmodule // dma_trigger_select_and_priority_bench
`default_nettype wire
